// *** rtl/sarro_top.sv ***
// sarro_top: serial conversion and readout port of a 16-bit converter
// assumes: pins asynchronous, sampled at 50 MHz; the core pushes results
// into a queue and the port loads the next one at each conversion end
// Overview of operation
// - trigger rise, input high: select mode, output floats
// - input and trigger both low drive output low
// - select conversion end with busy: output floats to low
// - result shifts MSB first on falling clock
// - output bit stable across both clock edges
// - float again at 17th fall (16th without busy) or input rise
// - trigger rise, clock low: chain mode, no busy
// - chain without busy shows MSB at completion
// - chain input feeds shift register on falling edge
// - trigger rise, clock high: chain mode with busy
// - chain with busy drives output high at end
// - input level at trigger rise chooses mode
// - select busy only if trigger or input low
`timescale 1ns/1ps
`default_nettype none
module sarro_top
    import sarro_pkg::*;
(
    // clock and reset
    input  wire logic                i_clk,
    input  wire logic                i_rst_n,
    // link pins
    input  wire logic                i_conversion_trigger,
    input  wire logic                i_serial_data_input,
    input  wire logic                i_sclk,
    output logic                     o_serial_data_output,
    output logic                     o_serial_data_output_oe,
    // result source
    input  wire logic                i_res_valid,
    output logic                     o_res_ready,
    input  wire logic [RESULT_W-1:0] i_res_data,
    // status
    output logic                     o_converting,
    output logic                     o_underrun
);
    // ********************************************
    // state
    // ********************************************
    typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_READ} sarro_st_t;
    typedef struct packed {
        sarro_pins_t         m1;        // first sync stage
        sarro_pins_t         m2;        // second sync stage
        sarro_pins_t         prev;      // previous synchronised value
        sarro_st_t           st;        // phase
        sarro_mode_t         mode;      // latched readout mode
        logic                busy_en;   // busy indication armed
        logic [5:0]          cnt;       // conversion or bit counter
        logic [RESULT_W-1:0] sh;        // output shift register
        logic                lead;      // busy start bit in front of data
        sarro_sdo_t          serial_data_output;       // pin drive
        logic                underrun;  // no result was queued
    } sarro_state_t;

    sarro_state_t        cur;
    sarro_state_t        next_cur;
    logic                q_valid;
    logic                q_take;
    logic [RESULT_W-1:0] q_data;

    // ********************************************
    // result queue
    // ********************************************
    sarro_fifo #(.WIDTH(RESULT_W), .DEPTH(FIFO_DEPTH)) u_fifo
    (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_valid (i_res_valid),
        .o_ready (o_res_ready),
        .i_data  (i_res_data),
        .o_valid (q_valid),
        .i_ready (q_take),
        .o_data  (q_data)
    );

    // ********************************************
    // next state
    // ********************************************
    logic trig_rise;
    logic sclk_fall;
    logic sdi_rise;
    logic done;
    always_comb
    begin
        next_cur    = cur;
        next_cur.m1 = '{trig: i_conversion_trigger, serial_data_input: i_serial_data_input, sclk: i_sclk};
        next_cur.m2 = cur.m1;
        next_cur.prev = cur.m2;
        trig_rise = cur.m2.trig && !cur.prev.trig;
        sclk_fall = !cur.m2.sclk && cur.prev.sclk;
        sdi_rise  = cur.m2.serial_data_input && !cur.prev.serial_data_input;
        done      = (cur.st == ST_CONV) && (cur.cnt == 6'h00);
        q_take    = 1'b0;
        unique case (cur.st)
            // waiting for a trigger
            ST_IDLE:
            begin
                next_cur.cnt = 6'h00;
            end
            // conversion running, output floats in select mode, driven low in chain mode
            ST_CONV:
            begin
                next_cur.cnt = cur.cnt - 6'h01;
                if (done)
                begin
                    // load the finished result
                    q_take        = q_valid;
                    next_cur.sh   = q_valid ? q_data : '0;
                    next_cur.underrun = cur.underrun | !q_valid;
                    next_cur.st   = ST_READ;
                    next_cur.cnt  = 6'h00;
                    // select mode busy armed by a low trigger or input
                    if (cur.mode == SARRO_SEL)
                    begin
                        next_cur.busy_en = !cur.m2.trig || !cur.m2.serial_data_input;
                    end
                    next_cur.lead = (cur.mode == SARRO_SEL)
                        ? (!cur.m2.trig || !cur.m2.serial_data_input) : cur.busy_en;
                end
            end
            // shifting out
            ST_READ:
            begin
                if (sclk_fall)
                begin
                    next_cur.cnt = cur.cnt + 6'h01;
                    if (cur.lead)
                    begin
                        next_cur.lead = 1'b0;
                    end
                    else
                    begin
                        // MSB first; chain input enters at the far end
                        next_cur.sh = {cur.sh[RESULT_W-2:0],
                                       (cur.mode == SARRO_CHAIN) ? cur.m2.serial_data_input : 1'b0};
                    end
                end
            end
            default:
            begin
                next_cur.st = ST_IDLE;
            end
        endcase
        // a trigger rise always starts a new conversion
        if (trig_rise)
        begin
            next_cur.st  = ST_CONV;
            next_cur.cnt = CONV_CNT;
            next_cur.mode = cur.m2.serial_data_input ? SARRO_SEL : SARRO_CHAIN;
            next_cur.busy_en = !cur.m2.serial_data_input && cur.m2.sclk;
        end
        // pin drive
        next_cur.serial_data_output = '{dat: 1'b0, oe: 1'b0};
        if (next_cur.st == ST_READ)
        begin
            if (next_cur.mode == SARRO_SEL)
            begin
                // selected read: input low, until 17th fall (16th without busy) or input rise
                if (!cur.m2.serial_data_input && next_cur.busy_en && !sdi_rise
                    && next_cur.cnt < (BIT_LAST + 6'h01))
                begin
                    next_cur.serial_data_output = '{dat: next_cur.lead ? 1'b0 : next_cur.sh[RESULT_W-1],
                                     oe: 1'b1};
                end
                else if (!cur.m2.serial_data_input && !next_cur.busy_en
                    && next_cur.cnt < BIT_LAST)
                begin
                    next_cur.serial_data_output = '{dat: next_cur.sh[RESULT_W-1], oe: 1'b1};
                end
            end
            else
            begin
                // chain: busy start bit high, else MSB
                next_cur.serial_data_output = '{dat: next_cur.lead ? 1'b1 : next_cur.sh[RESULT_W-1],
                                 oe: 1'b1};
            end
        end
        else if (next_cur.st == ST_CONV && next_cur.mode == SARRO_CHAIN)
        begin
            next_cur.serial_data_output = '{dat: 1'b0, oe: 1'b1};
        end
        // both low drives low in every phase; the host keeps trigger high while reading
        if (!cur.m2.serial_data_input && !cur.m2.trig)
        begin
            next_cur.serial_data_output = '{dat: 1'b0, oe: 1'b1};
        end
        if (trig_rise && cur.m2.serial_data_input)
        begin
            next_cur.serial_data_output = '{dat: 1'b0, oe: 1'b0};
        end
    end

    // state register
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cur <= '{st: ST_IDLE, mode: SARRO_SEL, default: '0};
        end
        else
        begin
            cur <= next_cur;
        end
    end

    // outputs change only on internal sample edges, so each bit holds a full clock period
    assign o_serial_data_output    = cur.serial_data_output.dat;
    assign o_serial_data_output_oe = cur.serial_data_output.oe;
    assign o_converting            = (cur.st == ST_CONV);
    assign o_underrun              = cur.underrun;

    // ********************************************
    // checks
    // ********************************************
    float_on_start_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (cur.m2.trig && !cur.prev.trig && cur.m2.serial_data_input) |=> !o_serial_data_output_oe)
        else $error("output not floated at select start");
    both_low_drive_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (!cur.m2.serial_data_input && !cur.m2.trig)
        |=> (o_serial_data_output_oe && !o_serial_data_output))
        else $error("output not driven low");
    conv_length_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $rose(o_converting) && !(cur.m2.trig && !cur.prev.trig)
        |-> o_converting [*3])
        else $error("conversion too short");
    sel_float_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (cur.st == ST_READ && cur.mode == SARRO_SEL && cur.cnt > BIT_LAST
         && ($past(cur.m2.trig) || $past(cur.m2.serial_data_input)))
        |-> !o_serial_data_output_oe)
        else $error("output not floated after last bit");
    chain_mode_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (cur.m2.trig && !cur.prev.trig && !cur.m2.serial_data_input)
        |=> (cur.mode == SARRO_CHAIN && cur.busy_en == $past(cur.m2.sclk)))
        else $error("chain mode not latched");
    chain_busy_high_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (cur.st == ST_READ && cur.mode == SARRO_CHAIN && cur.lead)
        |-> (o_serial_data_output_oe && o_serial_data_output))
        else $error("chain busy bit not high");
    shift_step_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (cur.st == ST_READ && !cur.lead && sclk_fall && !trig_rise)
        |=> (cur.sh[RESULT_W-1:1] == $past(cur.sh[RESULT_W-2:0])))
        else $error("shift register did not advance");
    sel_mode_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (cur.m2.trig && !cur.prev.trig && cur.m2.serial_data_input) |=> (cur.mode == SARRO_SEL))
        else $error("select mode not latched");
endmodule
`default_nettype wire

// *** rtl/sarro_pkg.sv ***
// sarro_pkg: shared constants and carrier types for the serial readout port
// assumes: one 50 MHz core clock; all link pins arrive asynchronously
package sarro_pkg;
    // ********************************************
    // widths and timing
    // ********************************************
    localparam int unsigned RESULT_W     = 16;         // conversion result width
    localparam int unsigned FIFO_DEPTH   = 16;         // result queue depth
    localparam int unsigned CLK_HZ       = 50000000;   // core clock rate
    localparam int unsigned CONV_MAX_NS  = 710;        // longest conversion time, ns
    // cycles for conversion, rounded down, 35 at 710 ns and 50 MHz
    localparam int unsigned CONV_CYC     = (CONV_MAX_NS * (CLK_HZ / 1000000)) / 1000;
    // six bits: the conversion count does not fit in five
    localparam logic [5:0]  CONV_CNT     = 6'(CONV_CYC);
    localparam logic [5:0]  BIT_LAST     = 6'h10;      // falling edge count ending read without busy; busy read ends one fall later

    // ********************************************
    // carriers
    // ********************************************
    typedef enum logic [1:0] {SARRO_SEL, SARRO_CHAIN} sarro_mode_t;

    // synchronised link pins
    typedef struct packed {
        logic trig;      // conversion_trigger
        logic serial_data_input;       // serial_data_input
        logic sclk;      // serial clock
    } sarro_pins_t;

    // serial data output pin as output and enable
    typedef struct packed {
        logic dat;
        logic oe;
    } sarro_sdo_t;
endpackage

// *** rtl/sarro_fifo.sv ***
// sarro_fifo: small valid/ready queue for conversion results
// assumes: both sides on i_clk
`timescale 1ns/1ps
`default_nettype none
module sarro_fifo
#(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 16
)
(
    // clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    // fill side
    input  wire logic             i_valid,
    output logic                  o_ready,
    input  wire logic [WIDTH-1:0] i_data,
    // drain side
    output logic                  o_valid,
    input  wire logic             i_ready,
    output logic      [WIDTH-1:0] o_data
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];    // storage
    logic [AW:0]      wr_ptr;         // write pointer with wrap bit
    logic [AW:0]      rd_ptr;         // read pointer with wrap bit
    logic             full;
    logic             empty;
    assign full    = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    assign empty   = (wr_ptr == rd_ptr);
    assign o_ready = !full;
    assign o_valid = !empty;
    assign o_data  = mem[rd_ptr[AW-1:0]];
    // pointers and storage
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            if (i_valid && !full)
            begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (i_ready && !empty)
            begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
    always_ff @(posedge i_clk)
    begin
        if (i_valid && !full)
        begin
            mem[wr_ptr[AW-1:0]] <= i_data;
        end
    end
endmodule
`default_nettype wire

// *** verif/sarro_host.sv ***
// sarro_host: behavioural host that starts conversions and clocks results out
// assumes: a pull-up holds the output line high while the converter floats it
`timescale 1ns/1ps
`default_nettype none
module sarro_host
(
    // converter output pin
    input  wire logic i_pin_dat,
    input  wire logic i_pin_oe,
    // converter input pins
    output logic      o_trig,
    output logic      o_sdi,
    output logic      o_sclk
);
    wire logic line;                            // level seen on the shared line

    // pull-up wins while the converter floats the pin
    assign line = i_pin_oe ? i_pin_dat : 1'b1;

    // pins idle, serial clock standing still
    initial
    begin
        o_trig = 1'b0;
        o_sdi  = 1'b1;
        o_sclk = 1'b0;
    end

    // start a conversion: mode 0 select with busy, 1 chain, 2 chain with busy,
    // 3 select without busy
    task automatic trigger(input int mode);
        o_sdi  = (mode == 0) || (mode == 3);
        o_sclk = (mode == 2);
        #80 o_trig = 1'b1;
        if (mode == 0)
        begin
            #100 o_sdi = 1'b0;
        end
    endtask

    // n falls; sample before each fall and once after the last
    task automatic shift(input int n, input logic [31:0] din, output logic [63:0] got);
        got = '0;
        for (int i = 0; i < n; i++)
        begin
            o_sclk = 1'b1;
            o_sdi  = din[i];                    // chain input stable across the fall
            #80 got[i] = line;
            o_sclk = 1'b0;
            #80;
        end
        #100 got[n] = line;
    endtask

    // end the read early by raising the input
    task automatic lift_sdi();
        o_sdi = 1'b1;
    endtask

    // end of frame: trigger and input low, clock parked
    task automatic release_pins();
        o_trig = 1'b0;
        o_sdi  = 1'b0;
        o_sclk = 1'b0;
    endtask
endmodule
`default_nettype wire

// *** verif/sar_adc_serial_readout_test.sv ***
// sar_adc_serial_readout_test: runs the readout port through every readout mode
// assumes: package, queue, port and host model are compiled before this file
`timescale 1ns/1ps
`default_nettype none
module sar_adc_serial_readout_test;
    import sarro_pkg::*;
    // ****************************************
    // signals
    // ****************************************
    logic                i_clk;          // core clock
    logic                i_rst_n;        // reset, active low
    logic                trig;           // conversion_trigger pin
    logic                serial_data_input;            // serial_data_input pin
    logic                sclk;           // serial clock pin
    logic                serial_data_output;            // output level
    logic                sdo_oe;         // output enable
    logic                res_valid;      // result push valid
    logic                res_ready;      // queue not full
    logic [RESULT_W-1:0] res_data;       // result word
    logic                conv;           // conversion phase
    logic                underrun;       // empty queue at conversion end
    int                  n_mismatch = 0;
    int                  n_checks = 0;
    int                  seed = 24353;
    int                  cyc = 0;
    logic [15:0]         q[$];           // model of queued results

    sarro_top sarro_top_inst (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_conversion_trigger(trig),
        .i_serial_data_input(serial_data_input), .i_sclk(sclk), .o_serial_data_output(serial_data_output),
        .o_serial_data_output_oe(sdo_oe), .i_res_valid(res_valid),
        .o_res_ready(res_ready), .i_res_data(res_data), .o_converting(conv),
        .o_underrun(underrun));
    sarro_host sarro_host_inst (
        .i_pin_dat(serial_data_output), .i_pin_oe(sdo_oe), .o_trig(trig), .o_sdi(serial_data_input), .o_sclk(sclk));

    // 50 MHz clock
    initial
    begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end

    // cut a hang short
    always @(posedge i_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_mismatch = n_mismatch + 1;
            close_out();
        end
    end

    // one comparison, reported at once on mismatch
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
        n_checks = n_checks + 1;
        if (seen !== exp)
        begin
            n_mismatch = n_mismatch + 1;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // verdict and end of run
    task automatic close_out();
        if (n_mismatch == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        logic [15:0] w;
        logic [31:0] din;
        logic [63:0] got;
        logic        e;
        int          mode;
        int          n;
        i_rst_n   = 1'b0;
        res_valid = 1'b0;
        res_data  = '0;
        repeat (2) @(posedge i_clk);
        #2 i_rst_n = 1'b1;
        repeat (3) @(posedge i_clk);
        // fill the queue until it refuses
        #2 res_valid = 1'b1;
        for (int i = 0; i < 17; i++)
        begin
            w        = 16'($random(seed));
            res_data = w;
            chk("res_ready", 16'(i < 16), 16'(res_ready));
            if (i < 16) q.push_back(w);
            @(posedge i_clk);
            #2;
        end
        res_valid = 1'b0;
        // drain one word per conversion, cycling modes, last one underruns
        for (int f = 0; f < 17; f++)
        begin
            mode = f % 4;
            w    = (q.size() > 0) ? q.pop_front() : 16'h0000;
            din  = $random(seed);
            sarro_host_inst.trigger(mode);
            repeat (20) @(posedge i_clk);
            #2 chk("converting", 16'h0001, 16'(conv));
            chk("oe in conversion", 16'(mode == 1 || mode == 2), 16'(sdo_oe));
            repeat (30) @(posedge i_clk);
            #2 chk("converting", 16'h0000, 16'(conv));
            chk("oe at end", 16'(mode != 3), 16'(sdo_oe));
            n = (mode == 1) ? 24 : ((mode == 3) ? 16 : ((f == 4) ? 5 : 17));
            sarro_host_inst.shift(n, (mode == 1) ? din : 32'h0, got);
            for (int j = 0; j <= n; j++)
            begin
                if (mode == 0)
                    e = (j == 0) ? 1'b0 : ((j <= 16) ? w[16 - j] : 1'b1);
                else if (mode == 1)
                    e = (j <= 15) ? w[15 - j] : din[j - 16];
                else if (mode == 2)
                    e = (j == 0) ? 1'b1 : ((j <= 16) ? w[16 - j] : 1'b0);
                else
                    e = (j <= 15) ? w[15 - j] : 1'b1;
                chk("sdo bit", 16'(e), 16'(got[j]));
            end
            if (mode == 0 || mode == 3)
            begin
                if (f == 4) sarro_host_inst.lift_sdi();
                repeat (10) @(posedge i_clk);
                #2 chk("oe after read", 16'h0000, 16'(sdo_oe));
            end
            sarro_host_inst.release_pins();
            repeat (10) @(posedge i_clk);
            #2 chk("oe idle", 16'h0001, 16'(sdo_oe));
            chk("sdo idle", 16'h0000, 16'(serial_data_output));
            chk("underrun", 16'(f == 16), 16'(underrun));
        end
        chk("res_ready", 16'h0001, 16'(res_ready));
        close_out();
    end
endmodule
`default_nettype wire
